// file: src/programmable_counter_array.sv
// Purpose: Programmable counter array with shared time base, six modules
//          and a watchdog on the last module, reached over APB.
// Assumes: Pin inputs synchronous to clk_sys except the external inputs,
//          which pass a two-stage synchroniser.
// Notes:   No interrupt logic; flags are sticky, cleared by writing one.
`timescale 1ns/1ps
`default_nettype none
module programmable_counter_array
  import counter_array_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    power_on_reset,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // System inputs
  input  wire logic                    timer0_overflow,
  input  wire logic                    debug_halt,
  input  wire logic                    external_count_input,
  input  wire logic                    ext_osc_clock,
  // Crossbar-routed module pins
  input  wire logic [counter_array_pkg::NUM_MODULES-1:0] module_pin_in,
  output logic [counter_array_pkg::NUM_MODULES-1:0]      module_pin_out,
  // Watchdog reset request
  output logic                         watchdog_reset
);
  import counter_array_pkg::*;

  function automatic logic is_mod_addr(input logic [7:0] a, input logic [7:0] base);
    is_mod_addr = (a >= base) && (a < base + 8'(4 * NUM_MODULES)) && (a[1:0] == 2'b00);
  endfunction : is_mod_addr

  // Configuration and status
  logic                    run;
  logic                    idle_stop;
  clock_source_type        source;
  logic [COUNT_WIDTH-1:0]  count;
  logic [NUM_MODULES-1:0]  flags;
  logic                    wd_enable;
  logic                    wd_lock;
  logic                    wd_lock_allowed;
  logic [COUNT_WIDTH-1:0]  wd_reload;
  module_mode_type         mode     [NUM_MODULES];
  logic [1:0]              edge_sel [NUM_MODULES];
  logic [COUNT_WIDTH-1:0]  cmp      [NUM_MODULES];

  logic                    next_run;
  logic                    next_idle_stop;
  clock_source_type        next_source;
  logic [COUNT_WIDTH-1:0]  next_count;
  logic [NUM_MODULES-1:0]  next_flags;
  logic                    next_wd_enable;
  logic                    next_wd_lock;
  logic                    next_wd_lock_allowed;
  logic [COUNT_WIDTH-1:0]  next_wd_reload;
  module_mode_type         next_mode     [NUM_MODULES];
  logic [1:0]              next_edge_sel [NUM_MODULES];
  logic [COUNT_WIDTH-1:0]  next_cmp      [NUM_MODULES];

  // Prescalers and synchronisers
  logic [3:0] div_sys;
  logic [3:0] next_div_sys;
  logic [2:0] div_osc;
  logic [2:0] next_div_osc;
  logic [1:0] eci_sync;
  logic       eci_prev;
  logic [1:0] osc_sync;
  logic       osc_prev;

  // Bus and registered outputs
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        next_watchdog_reset;
  logic [NUM_MODULES-1:0] next_pin_out;

  logic                    tick;
  logic                    eci_rise;
  logic                    osc_rise;
  logic [NUM_MODULES-1:0]  unit_event;
  logic [NUM_MODULES-1:0]  unit_pin;
  logic [COUNT_WIDTH-1:0]  unit_capture [NUM_MODULES];

  wire logic access = psel && penable && !pready;
  wire logic wr     = access && pwrite;
  wire logic [2:0] mod_idx = 3'(paddr[4:2]);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eci_sync <= 2'b00;
      osc_sync <= 2'b00;
      eci_prev <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      eci_sync <= {eci_sync[0], external_count_input};
      osc_sync <= {osc_sync[0], ext_osc_clock};
      eci_prev <= eci_sync[1];
      osc_prev <= osc_sync[1];
    end
  end

  assign eci_rise = eci_sync[1] && !eci_prev;
  assign osc_rise = osc_sync[1] && !osc_prev;

  // Counter clock selection and advance
  always_comb begin
    next_div_sys = div_sys;
    next_div_osc = div_osc;
    tick         = 1'b0;
    if (run && !(idle_stop && debug_halt)) begin
      next_div_sys = (div_sys == 4'(DIV_SYS_12 - 1)) ? 4'h0 : div_sys + 4'h1;
      if (osc_rise) begin
        next_div_osc = div_osc + 3'h1;
      end
      case (source)
        SRC_SYS_DIV12:    tick = (div_sys == 4'h0);
        SRC_SYS_DIV4:     tick = (div_sys[1:0] == 2'(DIV_SYS_4 - 1));
        SRC_TIMER0_OVF:   tick = timer0_overflow;
        SRC_EXT_COUNT:    tick = eci_rise;
        SRC_SYS_CLK:      tick = 1'b1;
        SRC_EXT_OSC_DIV8: tick = osc_rise && (div_osc == 3'(DIV_EXT_OSC_8 - 1));
        default:          tick = 1'b0;
      endcase
    end
    next_count = tick ? count + 16'h0001 : count;
  end

  // Register writes, flags and watchdog
  always_comb begin
    next_run             = run;
    next_idle_stop       = idle_stop;
    next_source          = source;
    next_flags           = flags;
    next_wd_enable       = wd_enable;
    next_wd_lock         = wd_lock;
    next_wd_lock_allowed = wd_lock_allowed && !(wr && paddr != OFS_WDOG);
    next_wd_reload       = wd_reload;
    next_mode            = mode;
    next_edge_sel        = edge_sel;
    next_cmp             = cmp;
    next_watchdog_reset  = 1'b0;
    if (wr) begin
      case (paddr)
        OFS_CONTROL: begin
          next_run       = pwdata[CTL_RUN_BIT];
          next_source    = clock_source_type'(pwdata[CTL_SRC_LSB +: CTL_SRC_WIDTH]);
          next_idle_stop = pwdata[CTL_IDLE_BIT];
        end
        OFS_FLAGS: next_flags = flags & ~pwdata[NUM_MODULES-1:0];
        OFS_WDOG: begin
          if (!wd_lock) begin
            next_wd_enable = pwdata[WD_ENABLE_BIT];
          end
          if (pwdata[WD_LOCK_BIT] && wd_lock_allowed) begin
            next_wd_lock   = 1'b1;
            next_wd_enable = 1'b1;
          end
          if (pwdata[WD_KICK_BIT]) begin
            next_wd_reload = cmp[WATCHDOG_MODULE];
          end
        end
        default: begin
          if (is_mod_addr(paddr, OFS_MOD_BASE)) begin
            next_mode[mod_idx]     = module_mode_type'(pwdata[MOD_MODE_LSB +: 3]);
            next_edge_sel[mod_idx] = {pwdata[MOD_FALL_BIT], pwdata[MOD_RISE_BIT]};
          end else if (is_mod_addr(paddr, OFS_CMP_BASE)) begin
            next_cmp[mod_idx] = pwdata[COUNT_WIDTH-1:0];
          end
        end
      endcase
    end
    next_flags = next_flags | unit_event; // Set wins over clear
    if (wd_enable && tick) begin
      if (wd_reload == 16'h0000) begin
        next_watchdog_reset = 1'b1;
        next_wd_reload      = cmp[WATCHDOG_MODULE];
      end else begin
        next_wd_reload = wd_reload - 16'h0001;
      end
    end
  end

  // Bus answers
  always_comb begin
    next_pready  = access;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (access && !pwrite) begin
      case (paddr)
        OFS_CONTROL:  next_prdata = {27'h0, idle_stop, 3'(source), run};
        OFS_MODE_SEL: next_prdata = 32'(NUM_MODULES);
        OFS_COUNT:    next_prdata = {16'h0000, count};
        OFS_FLAGS:    next_prdata = {26'h0, flags};
        OFS_WDOG:     next_prdata = {wd_reload, 14'h0, wd_lock, wd_enable};
        default: begin
          if (is_mod_addr(paddr, OFS_MOD_BASE)) begin
            next_prdata = {16'h0000, unit_capture[mod_idx]};
          end else if (is_mod_addr(paddr, OFS_CMP_BASE)) begin
            next_prdata = {16'h0000, cmp[mod_idx]};
          end else begin
            next_pslverr = 1'b1;
          end
        end
      endcase
    end else if (wr) begin
      next_pslverr = !(paddr == OFS_CONTROL || paddr == OFS_FLAGS || paddr == OFS_WDOG ||
                       is_mod_addr(paddr, OFS_MOD_BASE) || is_mod_addr(paddr, OFS_CMP_BASE));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run             <= 1'b0;
      idle_stop       <= 1'b1;
      source          <= SRC_SYS_DIV12;
      count           <= COUNT_RESET;
      flags           <= '0;
      wd_enable       <= 1'b1;
      wd_lock         <= 1'b0;
      // Only a power-on reset arms the lock; other resets leave it unarmed
      wd_lock_allowed <= power_on_reset;
      wd_reload       <= WD_RELOAD_RESET;
      div_sys         <= 4'h0;
      div_osc         <= 3'h0;
      pready          <= 1'b0;
      prdata          <= 32'h0000_0000;
      pslverr         <= 1'b0;
      watchdog_reset  <= 1'b0;
      module_pin_out  <= '0;
      for (int i = 0; i < NUM_MODULES; i++) begin
        mode[i]     <= (i == WATCHDOG_MODULE) ? MODE_SW_TIMER : MODE_OFF;
        edge_sel[i] <= 2'b00;
        cmp[i]      <= WD_RELOAD_RESET;
      end
    end else begin
      run             <= next_run;
      idle_stop       <= next_idle_stop;
      source          <= next_source;
      count           <= next_count;
      flags           <= next_flags;
      wd_enable       <= next_wd_enable;
      wd_lock         <= next_wd_lock;
      wd_lock_allowed <= power_on_reset ? 1'b1 : next_wd_lock_allowed;
      wd_reload       <= next_wd_reload;
      div_sys         <= next_div_sys;
      div_osc         <= next_div_osc;
      pready          <= next_pready;
      prdata          <= next_prdata;
      pslverr         <= next_pslverr;
      watchdog_reset  <= next_watchdog_reset;
      module_pin_out  <= next_pin_out;
      mode            <= next_mode;
      edge_sel        <= next_edge_sel;
      cmp             <= next_cmp;
    end
  end

  assign next_pin_out = unit_pin;

  for (genvar g = 0; g < NUM_MODULES; g++) begin : g_unit
    capture_compare_unit u_unit (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .tick          (tick),
      .count         (count),
      .mode          (mode[g]),
      .cap_rise      (edge_sel[g][0]),
      .cap_fall      (edge_sel[g][1]),
      .compare_value (cmp[g]),
      .pin_in        (module_pin_in[g]),
      .pin_out       (unit_pin[g]),
      .capture_value (unit_capture[g]),
      .event_pulse   (unit_event[g])
    );
  end

  count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    tick |=> count == $past(count) + 16'h0001) else $error("count missed a tick");
  halt_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (debug_halt && idle_stop) |-> !tick) else $error("tick during halt");
  sysclk_src_a: assert property (@(posedge clk_sys) disable iff (rst)
    (run && !debug_halt && source == SRC_SYS_CLK) |-> tick) else $error("sysclk no tick");
  wd_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
    wd_lock |=> wd_enable && wd_lock) else $error("locked watchdog disabled");
  wd_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> wd_enable && mode[WATCHDOG_MODULE] == MODE_SW_TIMER)
    else $error("watchdog not enabled after reset");
  wd_expire_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wd_enable && tick && wd_reload == 16'h0000) |=> watchdog_reset)
    else $error("watchdog did not fire");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    unit_event[0] |=> flags[0]) else $error("flag lost");
  sequence apb_setup_s;
    psel && !penable;
  endsequence : apb_setup_s

  sequence apb_access_s;
    psel && penable;
  endsequence : apb_access_s

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
    apb_setup_s ##1 apb_access_s |=> pready) else $error("no ready");

endmodule : programmable_counter_array
`default_nettype wire

// file: src/counter_array_pkg.sv
// Purpose: Shared constants and types for the programmable counter array.
// Assumes: APB slave, 32-bit data, one word per register.
// Notes:   Offsets, field positions, reset values and counts live here.
package counter_array_pkg;

  localparam int NUM_MODULES      = 6;
  localparam int WATCHDOG_MODULE  = 5;
  localparam int COUNT_WIDTH      = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_MODE_SEL = 8'h04;
  localparam logic [7:0] OFS_COUNT    = 8'h08;
  localparam logic [7:0] OFS_FLAGS    = 8'h0C;
  localparam logic [7:0] OFS_WDOG     = 8'h10;
  localparam logic [7:0] OFS_MOD_BASE = 8'h20;
  localparam logic [7:0] OFS_CMP_BASE = 8'h40;

  // Control register fields
  localparam int CTL_RUN_BIT    = 0;
  localparam int CTL_SRC_LSB    = 1;
  localparam int CTL_SRC_WIDTH  = 3;
  localparam int CTL_IDLE_BIT   = 4;

  // Watchdog register fields
  localparam int WD_ENABLE_BIT  = 0;
  localparam int WD_LOCK_BIT    = 1;
  localparam int WD_KICK_BIT    = 2;
  localparam logic [31:0] WD_KICK_KEY = 32'h0000_00A5;

  // Counter clock prescale counts
  localparam int DIV_SYS_12     = 12;
  localparam int DIV_SYS_4      = 4;
  localparam int DIV_EXT_OSC_8  = 8;

  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] WD_RELOAD_RESET = 16'hFFFF;

  typedef enum logic [2:0] {
    SRC_SYS_DIV12,
    SRC_SYS_DIV4,
    SRC_TIMER0_OVF,
    SRC_EXT_COUNT,
    SRC_SYS_CLK,
    SRC_EXT_OSC_DIV8
  } clock_source_type;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_CAPTURE,
    MODE_SW_TIMER,
    MODE_HS_OUTPUT,
    MODE_PWM8,
    MODE_PWM16,
    MODE_FREQ_OUT
  } module_mode_type;

  // Module mode register fields
  localparam int MOD_MODE_LSB   = 0;
  localparam int MOD_RISE_BIT   = 3;
  localparam int MOD_FALL_BIT   = 4;

endpackage : counter_array_pkg

// file: src/capture_compare_unit.sv
// Purpose: One capture/compare module driven by the shared time base.
// Assumes: Count tick is a one-cycle enable; pin input synchronous.
// Notes:   Event pulses to the top for flag setting.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_unit
  import counter_array_pkg::*;
(
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // Time base
  input  wire logic                           tick,
  input  wire logic [counter_array_pkg::COUNT_WIDTH-1:0] count,
  // Configuration
  input  wire counter_array_pkg::module_mode_type mode,
  input  wire logic                           cap_rise,
  input  wire logic                           cap_fall,
  input  wire logic [counter_array_pkg::COUNT_WIDTH-1:0] compare_value,
  // Pin side
  input  wire logic                           pin_in,
  output logic                                pin_out,
  // Results
  output logic [counter_array_pkg::COUNT_WIDTH-1:0]      capture_value,
  output logic                                event_pulse
);
  logic                   pin_prev;
  logic                   out_level;
  logic [7:0]             freq_count;
  logic                   next_pin_prev;
  logic                   next_out_level;
  logic [7:0]             next_freq_count;
  logic [COUNT_WIDTH-1:0] next_capture_value;
  logic                   next_event;

  always_comb begin
    next_pin_prev      = pin_in;
    next_out_level     = out_level;
    next_freq_count    = freq_count;
    next_capture_value = capture_value;
    next_event         = 1'b0;
    case (mode)
      MODE_CAPTURE: begin
        if ((cap_rise && pin_in && !pin_prev) || (cap_fall && !pin_in && pin_prev)) begin
          next_capture_value = count;
          next_event         = 1'b1;
        end
      end
      MODE_SW_TIMER: begin
        if (tick && count == compare_value) begin
          next_event = 1'b1;
        end
      end
      MODE_HS_OUTPUT: begin
        if (tick && count == compare_value) begin
          next_out_level = !out_level;
          next_event     = 1'b1;
        end
      end
      MODE_PWM8: begin
        next_out_level = (count[7:0] >= compare_value[7:0]);
        if (tick && count[7:0] == 8'hFF) begin
          next_event = 1'b1;
        end
      end
      MODE_PWM16: begin
        next_out_level = (count >= compare_value);
        if (tick && count == 16'hFFFF) begin
          next_event = 1'b1;
        end
      end
      MODE_FREQ_OUT: begin
        if (tick) begin
          if (freq_count == compare_value[7:0]) begin
            next_freq_count = 8'h00;
            next_out_level  = !out_level;
          end else begin
            next_freq_count = freq_count + 8'h01;
          end
        end
      end
      default: begin
        next_out_level  = 1'b0;
        next_freq_count = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_prev      <= 1'b0;
      out_level     <= 1'b0;
      freq_count    <= 8'h00;
      capture_value <= COUNT_RESET;
      event_pulse   <= 1'b0;
    end else begin
      pin_prev      <= next_pin_prev;
      out_level     <= next_out_level;
      freq_count    <= next_freq_count;
      capture_value <= next_capture_value;
      event_pulse   <= next_event;
    end
  end

  assign pin_out = out_level;

endmodule : capture_compare_unit
`default_nettype wire

// file: testbench/pin_model.sv
// Purpose: Pin-side model feeding the counter array through the crossbar.
// Assumes: External inputs are slow compared with clk_sys.
// Notes:   Lines idle low and stand still between bursts.
`timescale 1ns/1ps
`default_nettype none
module pin_model
  import counter_array_pkg::*;
(
  // Crossbar-routed inputs
  output logic                                      external_count_input,
  output logic                                      ext_osc_clock,
  output logic [counter_array_pkg::NUM_MODULES-1:0] module_pin_in
);
  initial begin
    external_count_input = 1'b0;
    ext_osc_clock        = 1'b0;
    module_pin_in        = '0;
  end

  // Each level lasts over two clk_sys periods so the synchroniser sees it
  task automatic count_pulses(input int n);
    repeat (n) begin
      #61 external_count_input = 1'b1;
      #67 external_count_input = 1'b0;
    end
  endtask : count_pulses

  task automatic osc_edges(input int n);
    repeat (n) begin
      #57 ext_osc_clock = 1'b1;
      #59 ext_osc_clock = 1'b0;
    end
  endtask : osc_edges

  task automatic set_pin(input int idx, input logic v);
    // Called on a clock edge: non-blocking so the design sees it next edge
    module_pin_in[idx] <= v;
  endtask : set_pin
endmodule : pin_model
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the programmable counter array.
// Assumes: APB answer after one wait state; pins come from pin_model.
// Notes:   Rates are checked in a window that covers bus overhead.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import counter_array_pkg::*;
  logic                   clk_sys, rst, power_on_reset, psel, penable, pwrite;
  logic                   pready, pslverr, timer0_overflow, debug_halt;
  logic                   external_count_input, ext_osc_clock, watchdog_reset;
  logic                   rd_err, pin_was;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd_data;
  logic [15:0]            c0, dl;
  logic [NUM_MODULES-1:0] module_pin_in, module_pin_out;
  int                     compares, mismatches, n;
  clock_source_type       srcs[3] = '{SRC_SYS_DIV12, SRC_SYS_DIV4, SRC_SYS_CLK};
  int                     divs[3] = '{12, 4, 1};

  programmable_counter_array u_dut (.clk_sys(clk_sys), .rst(rst),
    .power_on_reset(power_on_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer0_overflow(timer0_overflow), .debug_halt(debug_halt),
    .external_count_input(external_count_input), .ext_osc_clock(ext_osc_clock),
    .module_pin_in(module_pin_in), .module_pin_out(module_pin_out),
    .watchdog_reset(watchdog_reset));

  pin_model u_pins (.external_count_input(external_count_input),
    .ext_osc_clock(ext_osc_clock), .module_pin_in(module_pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] ctl(input logic [2:0] s, input logic r);
    return {27'h0, 1'b1, s, r};
  endfunction : ctl

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) `CHK("pready", 1'b1, pready)
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic start_src(input logic [2:0] s);
    wr(OFS_CONTROL, ctl(s, 1'b1));
    rd(OFS_COUNT);
    c0 = rd_data[15:0];
  endtask : start_src

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    #500000;
    mismatches++;
    results();
  end

  initial begin
    {rst, power_on_reset} = 2'b11;
    {psel, penable, pwrite, timer0_overflow, debug_halt} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk_sys);
    {rst, power_on_reset} <= 2'b00;
    rd(OFS_CONTROL); `CHK("control", 32'h10, rd_data)
    rd(OFS_MODE_SEL); `CHK("modules", 32'h6, rd_data)
    rd(OFS_COUNT); `CHK("count", 16'h0, rd_data[15:0])
    rd(OFS_WDOG); `CHK("wd_reset", 2'b01, rd_data[1:0])
    rd(8'h1C); `CHK("slverr", 1'b1, rd_err)
    wr(OFS_WDOG, 32'h0); rd(OFS_WDOG); `CHK("wd_off", 1'b0, rd_data[0])
    foreach (srcs[i]) begin
      wr(OFS_CONTROL, ctl(srcs[i], 1'b0));
      rd(OFS_COUNT);
      c0 = rd_data[15:0];
      wr(OFS_CONTROL, ctl(srcs[i], 1'b1));
      repeat (120) @(posedge clk_sys);
      wr(OFS_CONTROL, ctl(srcs[i], 1'b0));
      rd(OFS_COUNT);
      dl = rd_data[15:0] - c0;
      `CHK("rate", 1'b1, (dl >= 120 / divs[i] - 1 && dl <= 128 / divs[i] + 1))
    end
    wr(OFS_CONTROL, ctl(SRC_SYS_CLK, 1'b1));
    debug_halt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(OFS_COUNT);
    c0 = rd_data[15:0];
    repeat (20) @(posedge clk_sys);
    rd(OFS_COUNT); `CHK("halted", c0, rd_data[15:0])
    debug_halt <= 1'b0;
    start_src(SRC_EXT_COUNT);
    u_pins.count_pulses(10);
    repeat (6) @(posedge clk_sys);
    rd(OFS_COUNT); `CHK("ext_count", c0 + 16'd10, rd_data[15:0])
    start_src(SRC_EXT_OSC_DIV8);
    u_pins.osc_edges(24);
    repeat (6) @(posedge clk_sys);
    rd(OFS_COUNT); `CHK("ext_osc", c0 + 16'd3, rd_data[15:0])
    start_src(SRC_TIMER0_OVF);
    repeat (5) begin
      @(posedge clk_sys);
      timer0_overflow <= 1'b1;
      @(posedge clk_sys);
      timer0_overflow <= 1'b0;
    end
    rd(OFS_COUNT); `CHK("timer0", c0 + 16'd5, rd_data[15:0])
    wr(OFS_CONTROL, ctl(SRC_SYS_CLK, 1'b0));
    rd(OFS_COUNT);
    c0 = rd_data[15:0];
    wr(OFS_MOD_BASE, 32'h9);
    u_pins.set_pin(0, 1'b1);
    repeat (6) @(posedge clk_sys);
    rd(OFS_MOD_BASE); `CHK("capture", c0, rd_data[15:0])
    rd(OFS_FLAGS); `CHK("cap_flag", 1'b1, rd_data[0])
    wr(OFS_FLAGS, 32'h1);
    rd(OFS_FLAGS); `CHK("flag_clr", 1'b0, rd_data[0])
    wr(OFS_CONTROL, ctl(SRC_SYS_CLK, 1'b1));
    for (int m = 3; m <= 6; m++) begin
      rd(OFS_COUNT);
      wr(OFS_CMP_BASE + 8'(4 * (m - 2)), {16'h0, rd_data[15:0] + 16'd60});
      wr(OFS_MOD_BASE + 8'(4 * (m - 2)), 32'(m));
      pin_was = module_pin_out[m-2];
      n = 0;
      while (module_pin_out[m-2] === pin_was && n < 400) begin
        @(posedge clk_sys);
        n++;
      end
      `CHK("pin_moves", 1'b1, module_pin_out[m-2] !== pin_was)
    end
    wr(OFS_CMP_BASE + 8'd20, 32'd20);
    wr(OFS_WDOG, WD_KICK_KEY);
    n = 0;
    while (watchdog_reset !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("wd_fire", 1'b1, (watchdog_reset === 1'b1 && n >= 15))
    {rst, power_on_reset} <= 2'b11;
    repeat (3) @(posedge clk_sys);
    {rst, power_on_reset} <= 2'b00;
    rd(OFS_WDOG); `CHK("wd_reset", 2'b01, rd_data[1:0])
    wr(OFS_WDOG, 32'h3);
    wr(OFS_WDOG, 32'h0);
    rd(OFS_WDOG); `CHK("wd_locked", 1'b1, rd_data[0])
    results();
  end
endmodule : testbench
`default_nettype wire
